// >>> bench/ahp_host_model.sv
// Purpose: Motherboard switch inputs seen by the controller
// Assumes: Both switch inputs carry pull-ups
// Notes:   Released pins read high, never a stale level
`timescale 1ns/100ps
`default_nettype none
module ahp_host_model (
  input  wire logic pwr_drv_i,
  input  wire logic pwr_oe_i,
  input  wire logic rst_drv_i,
  input  wire logic rst_oe_i,
  output wire logic pwr_pin_o,
  output wire logic rst_pin_o
);
  // Pins stay wired to the switch inputs, never reused as plain I/O
  assign pwr_pin_o = pwr_oe_i ? pwr_drv_i : 1'h1;
  assign rst_pin_o = rst_oe_i ? rst_drv_i : 1'h1;
endmodule // ahp_host_model
`default_nettype wire

// >>> bench/ahp_power_ctrl_sva.sv
// Purpose: Port checks for the host power controller
// Assumes: TICK_CYCLES handed on from the instance
// Notes:   Pulse lengths tracked by run counters
`timescale 1ns/100ps
`default_nettype none
module ahp_power_ctrl_sva #(
  parameter TICK_CYCLES = 4
) (
  input wire logic       sys_clk_i,
  input wire logic       rst_b_i,
  input wire logic       key_confirm_i,
  input wire logic       key_cancel_i,
  input wire logic       cmd_valid_i,
  input wire logic [5:0] cmd_code_i,
  input wire logic [4:0] cmd_len_i,
  input wire logic       pwr_sw_o,
  input wire logic       pwr_sw_oe_o,
  input wire logic       rst_sw_oe_o,
  input wire logic       blank_o,
  input wire logic       host_on_o,
  input wire logic       self_reset_o,
  input wire logic       cfg_saved_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!rst_b_i);
  // Wide counter: a full-rate power pulse runs past the int range
  longint pwr_run = 0;
  int     rst_run = 0;
  always @(posedge sys_clk_i) begin
    pwr_run <= (rst_b_i && pwr_sw_oe_o) ? pwr_run + 1 : 0;
    rst_run <= (rst_b_i && rst_sw_oe_o) ? rst_run + 1 : 0;
  end
  sequence s_pwr_drive; pwr_sw_oe_o [*2]; endsequence
  sequence s_host_up; host_on_o [*3]; endsequence
  property p_pwr_level; s_pwr_drive |-> $stable(pwr_sw_o); endproperty
  a_pwr_level: assert property (p_pwr_level) else $error("power level moved");
  property p_pwr_cause; $rose(pwr_sw_oe_o) |-> $past(key_confirm_i || key_cancel_i, 6); endproperty
  a_pwr_cause: assert property (p_pwr_cause) else $error("power pulse no key");
  // Width 255 plus the 160 tick extension bounds every power pulse
  property p_pwr_max; pwr_sw_oe_o |-> pwr_run < 417 * longint'(TICK_CYCLES); endproperty
  a_pwr_max: assert property (p_pwr_max) else $error("power pulse too long");
  property p_rst_width;
    $fell(rst_sw_oe_o) |-> rst_run >= 31 * TICK_CYCLES && rst_run <= 32 * TICK_CYCLES + 2;
  endproperty
  a_rst_width: assert property (p_rst_width) else $error("reset pulse width");
  property p_self_after; self_reset_o |-> $past(rst_sw_oe_o) || $past(rst_sw_oe_o, 2); endproperty
  a_self_after: assert property (p_self_after) else $error("self reset stray");
  property p_self_once; self_reset_o |=> !self_reset_o; endproperty
  a_self_once: assert property (p_self_once) else $error("self reset long");
  property p_blank; s_host_up |-> !blank_o; endproperty
  a_blank: assert property (p_blank) else $error("blank with host on");
  property p_save;
    cfg_saved_o == $past(cmd_valid_i && cmd_code_i == 6'h04 && cmd_len_i == 5'h00);
  endproperty
  a_save: assert property (p_save) else $error("save ack mismatch");
endmodule // ahp_power_ctrl_sva
bind ahp_power_ctrl ahp_power_ctrl_sva #(.TICK_CYCLES(TICK_CYCLES)) ahp_power_ctrl_sva_inst (.*);
`default_nettype wire

// >>> bench/tb.sv
// Purpose: Self-checking bench for the host power controller
// Assumes: TICK_CYCLES shortened to 4
// Notes:   Pin inputs fed back through the host model
`timescale 1ns/100ps
`default_nettype none
module tb;
  localparam int T = 4;
  typedef struct packed {
    logic [4:0] len;
    logic [7:0] fn;
    logic [7:0] src;
    logic [3:0] io;
  } ahp_row_t;
  // io holds dedicated sense, legacy sense, expected host on, expected blank
  ahp_row_t rows [5] = '{
    '{5'h03, 8'hF1, 8'h01, 4'h5},
    '{5'h03, 8'hF1, 8'h01, 4'hA},
    '{5'h03, 8'hF1, 8'h00, 4'h9},
    '{5'h02, 8'hE1, 8'h01, 4'h6},
    '{5'h03, 8'hE1, 8'h01, 4'h4}
  };
  logic sys_clk_i = 0, rst_b_i = 0, sense_ded_i = 0, sense_gpio_i = 0, wdog_reset_i = 0;
  logic key_confirm_i = 0, key_cancel_i = 0, cmd_valid_i = 0, lvl, srs, ack;
  logic [5:0] cmd_code_i = 6'h00;
  logic [4:0] cmd_len_i = 5'h00;
  logic [7:0] cmd_data0_i = 8'h00, cmd_data1_i = 8'h00, cmd_data2_i = 8'h00;
  wire logic pwr_sw_i, rst_sw_i, pwr_sw_o, pwr_sw_oe_o, rst_sw_o, rst_sw_oe_o;
  wire logic blank_o, host_on_o, self_reset_o, cfg_saved_o;
  int mismatches = 0, num_checks = 0, pre, len;
  ahp_power_ctrl #(.TICK_CYCLES(T)) ahp_power_ctrl_inst (.*);
  ahp_host_model ahp_host_model_inst (.pwr_drv_i(pwr_sw_o), .pwr_oe_i(pwr_sw_oe_o),
    .rst_drv_i(rst_sw_o), .rst_oe_i(rst_sw_oe_o), .pwr_pin_o(pwr_sw_i), .rst_pin_o(rst_sw_i));
  initial forever #2 sys_clk_i = ~sys_clk_i;
  task automatic step(input int n);
    repeat (n) @(posedge sys_clk_i);
    #1;
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic rng(input string what, input int v, input int lo, input int hi);
    chk(what, 16'(v >= lo && v <= hi), 16'h0001);
  endtask
  task automatic cmd(input logic [5:0] c, input logic [4:0] l, input logic [7:0] a, b, d);
    {cmd_valid_i, cmd_code_i, cmd_len_i, cmd_data0_i, cmd_data1_i, cmd_data2_i} = {1'h1, c, l, a, b, d};
    step(1);
    cmd_valid_i = 0;
    ack = cfg_saved_o;
    step(1);
  endtask
  // Bounded waits for one pin pulse; self reset seen during or just after it
  task automatic pulse(input logic rs);
    pre = 0;
    len = 0;
    srs = 0;
    while ((rs ? rst_sw_oe_o : pwr_sw_oe_o) !== 1'h1 && pre < 3000) begin
      step(1);
      pre++;
    end
    lvl = rs ? rst_sw_o : pwr_sw_o;
    while ((rs ? rst_sw_oe_o : pwr_sw_oe_o) === 1'h1 && len < 3000) begin
      step(1);
      len++;
      srs |= self_reset_o;
    end
    repeat (3) begin
      step(1);
      srs |= self_reset_o;
    end
    if (pre >= 3000 || len >= 3000) begin
      mismatches++;
      results();
    end
  endtask
  initial begin
    step(2);
    rst_b_i = 1;
    chk("idle", {pwr_sw_oe_o, rst_sw_oe_o, blank_o, self_reset_o, cfg_saved_o}, 16'h0000);
    foreach (rows[i]) begin
      cmd(6'h1C, rows[i].len, rows[i].fn, 8'h10, rows[i].src);
      {sense_ded_i, sense_gpio_i} = rows[i].io[3:2];
      step(8);
      chk("host_on", host_on_o, rows[i].io[1]);
      chk("blank", blank_o, rows[i].io[0]);
    end
    $display("test rows done");
    cmd(6'h1C, 5'h03, 8'hB1, 8'h10, 8'h01);
    sense_ded_i = 0;
    key_confirm_i = 1;
    step(12 * T);
    chk("on_disabled", pwr_sw_oe_o, 1'h0);
    // A hold that began while disabled never fires; press afresh
    key_confirm_i = 0;
    step(4);
    cmd(6'h1C, 5'h03, 8'hF1, 8'h10, 8'h01);
    key_confirm_i = 1;
    pulse(0);
    chk("on_level", lvl, 1'h0);
    rng("on_hold", pre, 7 * T, 8 * T + 8);
    rng("on_width", len, 15 * T, 16 * T + 2);
    step(12 * T);
    chk("on_once", pwr_sw_oe_o, 1'h0);
    key_confirm_i = 0;
    step(1);
    key_confirm_i = 1;
    step(4 * T);
    key_confirm_i = 0;
    step(12 * T);
    chk("early_release", pwr_sw_oe_o, 1'h0);
    // Fixed polarity, power invert set, short width
    cmd(6'h1C, 5'h03, 8'h44, 8'h04, 8'h01);
    key_confirm_i = 1;
    pulse(0);
    key_confirm_i = 0;
    chk("on_inv_level", lvl, 1'h1);
    rng("on_short", len, 3 * T, 4 * T + 2);
    $display("test power on done");
    cmd(6'h1C, 5'h03, 8'hF1, 8'h10, 8'h01);
    sense_ded_i = 1;
    key_cancel_i = 1;
    pulse(0);
    key_cancel_i = 0;
    chk("off_level", lvl, 1'h0);
    rng("off_hold", pre, 127 * T, 128 * T + 8);
    rng("off_width", len, 175 * T, 176 * T + 4);
    $display("test power off done");
    cmd(6'h04, 5'h00, 8'h00, 8'h00, 8'h00);
    chk("saved", ack, 1'h1);
    cmd(6'h1C, 5'h03, 8'h22, 8'h10, 8'h01);
    key_confirm_i = 1;
    pulse(1);
    key_confirm_i = 0;
    chk("rst_level", lvl, 1'h1);
    rng("rst_hold", pre, 127 * T, 128 * T + 8);
    rng("rst_width", len, 31 * T, 32 * T + 2);
    chk("self_reset", srs, 1'h1);
    sense_ded_i = 0;
    step(8);
    chk("boot_blank", blank_o, 1'h1);
    $display("test keypad reset done");
    wdog_reset_i = 1;
    step(1);
    wdog_reset_i = 0;
    pulse(1);
    chk("wdog_level", lvl, 1'h0);
    rng("wdog_start", pre, 0, 4);
    rng("wdog_width", len, 31 * T, 32 * T + 2);
    chk("wdog_no_self", srs, 1'h0);
    $display("test watchdog done");
    // Mid-run reset drops the saved blanking back to the defaults
    rst_b_i = 0;
    step(2);
    rst_b_i = 1;
    chk("rst_idle", {pwr_sw_oe_o, rst_sw_oe_o, blank_o, self_reset_o, cfg_saved_o}, 16'h0000);
    step(8);
    chk("rst_defaults", blank_o, 1'h0);
    $display("test mid reset done");
    results();
  end
endmodule // tb
`default_nettype wire

// >>> rtl/ahp_atx_map.vh
// Purpose: Constants for the host power and reset controller
// Assumes: 250 MHz system clock
// Notes:   Hold and pulse times are counted in 1/32 s ticks
`ifndef AHP_ATX_MAP_VH
`define AHP_ATX_MAP_VH

`define AHP_CLK_PERIOD_NS   4
`define AHP_TICK_NS         31250000
`define AHP_TICKS_PER_S     32

// Command codes and lengths
`define AHP_CMD_ATX_CFG     6'h1C
`define AHP_CMD_ATX_LEN     5'h03
`define AHP_CMD_SAVE_BOOT   6'h04
`define AHP_CMD_SAVE_LEN    5'h00

// Function byte field positions
`define AHP_F_AUTO_POL      0
`define AHP_F_RST_INV       1
`define AHP_F_PWR_INV       2
`define AHP_F_BLANK_EN      4
`define AHP_F_RST_EN        5
`define AHP_F_PWR_ON_EN     6
`define AHP_F_PWR_OFF_EN    7

// Boot state after power-up
`define AHP_RST_FUNC        8'h00
`define AHP_RST_WIDTH       8'h20
`define AHP_RST_SENSE_SRC   8'h01
`define AHP_SENSE_DEDICATED 8'h01

// Times in milliseconds
`define AHP_ON_HOLD_MS      250
`define AHP_LONG_HOLD_MS    4000
`define AHP_RST_PULSE_MS    1000
`define AHP_EXTEND_MS       5000

`define AHP_MS_TO_TICKS(ms) (((ms) * `AHP_TICKS_PER_S) / 1000)

`endif

// >>> rtl/ahp_hold_cnt.v
// Purpose: Counts ticks while a synchronised key stays held
// Assumes: key_i and tick_i are on sys_clk_i
// Notes:   Saturates, clears on release
`timescale 1ns/100ps
`default_nettype none
module ahp_hold_cnt (
  input  wire       sys_clk_i,
  input  wire       rst_b_i,
  input  wire       key_i,
  input  wire       tick_i,
  output reg  [7:0] held_o
);
  always @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      held_o <= 8'h00;
    end else if (!key_i) begin
      held_o <= 8'h00;
    end else if (tick_i && (held_o != 8'hFF)) begin
      held_o <= held_o + 8'h01;
    end
  end
endmodule // ahp_hold_cnt
`default_nettype wire

// >>> rtl/ahp_power_ctrl.v
// Purpose: Keypad driven power and reset pulses for an attached PC host
// Assumes: Pin inputs asynchronous; command strobe on sys_clk_i
// Notes:   Pins float unless a pulse is in progress
// How it works
// - Power switch pin floats, drives only during pulses, level from power invert, or against its idle level with auto polarity.
// - Reset pin floats, drives only during pulses, level from reset invert, or against its idle level with auto polarity.
// - Host off, enabled: confirm held 0.25 s starts power pulse of configured width.
// - Host on, enabled: cancel held 4 s drives power pin at least configured width.
// - Cancel still held after minimum: keep driving while held, up to 5 s more.
// - Host on, enabled: confirm held 4 s drives reset pin for 1 s.
// - Right after a keypad reset pulse the device resets itself.
// - Blank option on: display blanked whenever host sense is low.
// - Power on, power off, reset and blanking are each enabled separately.
// - Watchdog host reset uses the same reset pin as keypad resets.
// - Command 28 with three bytes; first byte holds function enables.
// - Second byte is pulse width; 16 means half a second.
// - Third byte 1 selects dedicated sense input, otherwise legacy pin.
// - Command 4 without data saves current configuration as boot state.
`include "ahp_atx_map.vh"
`timescale 1ns/100ps
`default_nettype none
module ahp_power_ctrl #(
  parameter TICK_CYCLES = `AHP_TICK_NS / `AHP_CLK_PERIOD_NS
) (
  input  wire       sys_clk_i,
  input  wire       rst_b_i,
  input  wire       sense_ded_i,
  input  wire       sense_gpio_i,
  input  wire       key_confirm_i,
  input  wire       key_cancel_i,
  input  wire       pwr_sw_i,
  input  wire       rst_sw_i,
  input  wire       wdog_reset_i,
  input  wire       cmd_valid_i,
  input  wire [5:0] cmd_code_i,
  input  wire [4:0] cmd_len_i,
  input  wire [7:0] cmd_data0_i,
  input  wire [7:0] cmd_data1_i,
  input  wire [7:0] cmd_data2_i,
  output reg        pwr_sw_o,
  output reg        pwr_sw_oe_o,
  output reg        rst_sw_o,
  output reg        rst_sw_oe_o,
  output reg        blank_o,
  output reg        host_on_o,
  output reg        self_reset_o,
  output reg        cfg_saved_o
);
  // Worked out as integers, then cut to the 8-bit tick counters on purpose
  localparam integer ON_HOLD_N  = `AHP_MS_TO_TICKS(`AHP_ON_HOLD_MS);
  localparam integer LNG_HOLD_N = `AHP_MS_TO_TICKS(`AHP_LONG_HOLD_MS);
  localparam integer RST_LEN_N  = `AHP_MS_TO_TICKS(`AHP_RST_PULSE_MS);
  localparam integer EXT_LEN_N  = `AHP_MS_TO_TICKS(`AHP_EXTEND_MS);
  localparam [7:0]   ON_HOLD    = ON_HOLD_N[7:0];
  localparam [7:0]   LNG_HOLD   = LNG_HOLD_N[7:0];
  localparam [7:0]   RST_LEN    = RST_LEN_N[7:0];
  localparam [7:0]   EXT_LEN    = EXT_LEN_N[7:0];

  localparam [5:0] S_IDLE = 6'h01;
  localparam [5:0] S_PON  = 6'h02;
  localparam [5:0] S_POFF = 6'h04;
  localparam [5:0] S_PEXT = 6'h08;
  localparam [5:0] S_RST  = 6'h10;
  localparam [5:0] S_BOOT = 6'h20;

  // Two-stage synchronisers for all pin inputs
  wire [5:0] pin_raw = {rst_sw_i, pwr_sw_i, key_cancel_i, key_confirm_i,
                        sense_gpio_i, sense_ded_i};
  reg  [5:0] sync_a;
  reg  [5:0] sync_b;
  genvar gi;
  generate
    for (gi = 0; gi < 6; gi = gi + 1) begin : g_sync
      always @(posedge sys_clk_i) begin
        if (!rst_b_i) begin
          sync_a[gi] <= 1'b0;
          sync_b[gi] <= 1'b0;
        end else begin
          sync_a[gi] <= pin_raw[gi];
          sync_b[gi] <= sync_a[gi];
        end
      end
    end
  endgenerate
  wire ded_s     = sync_b[0];
  wire gpio_s    = sync_b[1];
  wire confirm_s = sync_b[2];
  wire cancel_s  = sync_b[3];
  wire pwr_pin_s = sync_b[4];
  wire rst_pin_s = sync_b[5];

  // Configuration, live and boot copies
  reg [7:0] func;
  reg [7:0] width;
  reg [7:0] src;
  reg [7:0] boot_func;
  reg [7:0] boot_width;
  reg [7:0] boot_src;

  wire sense = (src == `AHP_SENSE_DEDICATED) ? ded_s : gpio_s;

  // Tick of 1/32 s
  reg  [31:0] tick_cnt;
  wire        tick = (tick_cnt == TICK_CYCLES - 1);
  always @(posedge sys_clk_i) begin
    if (!rst_b_i || tick) begin
      tick_cnt <= 32'h0000_0000;
    end else begin
      tick_cnt <= tick_cnt + 32'h0000_0001;
    end
  end

  wire [7:0] held_confirm;
  wire [7:0] held_cancel;
  ahp_hold_cnt u_confirm (
    .sys_clk_i (sys_clk_i),
    .rst_b_i   (rst_b_i),
    .key_i     (confirm_s),
    .tick_i    (tick),
    .held_o    (held_confirm)
  );
  ahp_hold_cnt u_cancel (
    .sys_clk_i (sys_clk_i),
    .rst_b_i   (rst_b_i),
    .key_i     (cancel_s),
    .tick_i    (tick),
    .held_o    (held_cancel)
  );

  reg [5:0] state;
  reg [7:0] pcnt;
  reg       c_fired;
  reg       x_fired;
  reg       from_key;
  reg       idle_pwr;
  reg       idle_rst;

  // Pulse width 0 would also end at the first tick; treat as one tick
  wire [7:0] min_w = (width == 8'h00) ? 8'h01 : width;

  wire go_on  = func[`AHP_F_PWR_ON_EN] && !sense && !c_fired &&
                (held_confirm == ON_HOLD);
  wire go_off = func[`AHP_F_PWR_OFF_EN] && sense && !x_fired &&
                (held_cancel == LNG_HOLD);
  wire go_rst = func[`AHP_F_RST_EN] && sense && !c_fired &&
                (held_confirm == LNG_HOLD);

  // Auto polarity drives against the level the pin rests at
  wire pwr_lvl = func[`AHP_F_AUTO_POL] ? ~idle_pwr : func[`AHP_F_PWR_INV];
  wire rst_lvl = func[`AHP_F_AUTO_POL] ? ~idle_rst : func[`AHP_F_RST_INV];

  wire cfg_cmd  = cmd_valid_i && (cmd_code_i == `AHP_CMD_ATX_CFG) &&
                  (cmd_len_i == `AHP_CMD_ATX_LEN);
  wire save_cmd = cmd_valid_i && (cmd_code_i == `AHP_CMD_SAVE_BOOT) &&
                  (cmd_len_i == `AHP_CMD_SAVE_LEN);

  always @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      state        <= S_IDLE;
      pcnt         <= 8'h00;
      c_fired      <= 1'b0;
      x_fired      <= 1'b0;
      from_key     <= 1'b0;
      idle_pwr     <= 1'b0;
      idle_rst     <= 1'b0;
      func         <= `AHP_RST_FUNC;
      width        <= `AHP_RST_WIDTH;
      src          <= `AHP_RST_SENSE_SRC;
      boot_func    <= `AHP_RST_FUNC;
      boot_width   <= `AHP_RST_WIDTH;
      boot_src     <= `AHP_RST_SENSE_SRC;
      self_reset_o <= 1'b0;
      cfg_saved_o  <= 1'b0;
    end else begin
      self_reset_o <= 1'b0;
      cfg_saved_o  <= 1'b0;
      if (!confirm_s) begin
        c_fired <= 1'b0;
      end
      if (!cancel_s) begin
        x_fired <= 1'b0;
      end
      if (cfg_cmd) begin
        func  <= cmd_data0_i;
        width <= cmd_data1_i;
        src   <= cmd_data2_i;
      end
      if (save_cmd) begin
        boot_func   <= func;
        boot_width  <= width;
        boot_src    <= src;
        cfg_saved_o <= 1'b1;
      end
      case (state)
        S_IDLE: begin
          idle_pwr <= pwr_pin_s;
          idle_rst <= rst_pin_s;
          pcnt     <= 8'h00;
          if (wdog_reset_i) begin
            state    <= S_RST;
            from_key <= 1'b0;
          end else if (go_rst) begin
            state    <= S_RST;
            from_key <= 1'b1;
            c_fired  <= 1'b1;
          end else if (go_on) begin
            state   <= S_PON;
            c_fired <= 1'b1;
          end else if (go_off) begin
            state   <= S_POFF;
            x_fired <= 1'b1;
          end
        end
        S_PON: begin
          if (tick) begin
            pcnt <= pcnt + 8'h01;
            if (pcnt + 8'h01 >= min_w) begin
              state <= S_IDLE;
            end
          end
        end
        S_POFF: begin
          if (tick) begin
            pcnt <= pcnt + 8'h01;
            if (pcnt + 8'h01 >= min_w) begin
              pcnt  <= 8'h00;
              state <= cancel_s ? S_PEXT : S_IDLE;
            end
          end
        end
        S_PEXT: begin
          if (!cancel_s) begin
            state <= S_IDLE;
          end else if (tick) begin
            pcnt <= pcnt + 8'h01;
            if (pcnt + 8'h01 >= EXT_LEN) begin
              state <= S_IDLE;
            end
          end
        end
        S_RST: begin
          if (tick) begin
            pcnt <= pcnt + 8'h01;
            if (pcnt + 8'h01 >= RST_LEN) begin
              state <= from_key ? S_BOOT : S_IDLE;
            end
          end
        end
        S_BOOT: begin
          // Self reset reloads the saved boot state
          self_reset_o <= 1'b1;
          func         <= boot_func;
          width        <= boot_width;
          src          <= boot_src;
          state        <= S_IDLE;
        end
        default: begin
          state <= S_IDLE;
        end
      endcase
    end
  end

  // Registered pin drive and display state
  always @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      pwr_sw_o    <= 1'b0;
      pwr_sw_oe_o <= 1'b0;
      rst_sw_o    <= 1'b0;
      rst_sw_oe_o <= 1'b0;
      blank_o     <= 1'b0;
      host_on_o   <= 1'b0;
    end else begin
      pwr_sw_oe_o <= (state == S_PON) || (state == S_POFF) ||
                     (state == S_PEXT);
      pwr_sw_o    <= pwr_lvl;
      rst_sw_oe_o <= (state == S_RST);
      rst_sw_o    <= rst_lvl;
      blank_o     <= func[`AHP_F_BLANK_EN] && !sense;
      host_on_o   <= sense;
    end
  end
endmodule // ahp_power_ctrl
`default_nettype wire
